// file: rtl/eac_pkg.sv
// Purpose: Shared constants for the EEPROM access control block.
// Assumes: One 250 MHz core clock; the write timer derives a 1 MHz tick.
// Notes: I/O select codes pick one of four byte registers.
package eac_pkg;
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned OSC_PERIOD_NS = 1000;
    localparam int unsigned OSC_DIV = OSC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned WRITE_OSC_CYCLES = 8448;
    localparam int unsigned MWE_HOLD_CYCLES = 4;
    localparam int unsigned WRITE_STALL_CYCLES = 2;
    localparam int unsigned READ_STALL_CYCLES = 4;
    localparam int unsigned ADDR_W = 9;
    localparam int unsigned DEPTH = 512;
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_ADDR_LO = 2'h1;
    localparam logic [1:0] SEL_ADDR_HI = 2'h2;
    localparam logic [1:0] SEL_DATA = 2'h3;
    localparam int unsigned BIT_READY_IRQ_ENABLE = 3;
    localparam int unsigned BIT_MASTER_WRITE_ENABLE = 2;
    localparam int unsigned BIT_WRITE_STROBE = 1;
    localparam int unsigned BIT_READ_STROBE = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [8:0] ADDR_RESET = 9'h000;
endpackage : eac_pkg

// file: rtl/eac_mem.sv
// Purpose: Byte-wide storage array for the data EEPROM.
// Assumes: Write and read requests are single-cycle pulses.
// Notes: Read data appear in a register one cycle after the request.
module eac_mem #(
    parameter int unsigned AW = 9,
    parameter int unsigned DEPTH = 512
) (
    // Clock.
    input wire logic ref_clk,
    // Access.
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata_q
);
    logic [7:0] cells [DEPTH];

    always_ff @(posedge ref_clk)
    begin
        if (wr_en)
        begin
            cells[addr] <= wdata;
        end
        if (rd_en)
        begin
            rdata_q <= cells[addr];
        end
    end
endmodule : eac_mem

// file: rtl/eac_ctrl.sv
// Purpose: CPU-side control of byte reads and self-timed writes to EEPROM.
// Assumes: I/O strobes are synchronous to ref_clk and last one cycle.
// Notes: The write timer runs from a 1 MHz tick divided down from ref_clk.
//
// Behaviour
// - Control bits 7..4 read as zero.
// - Ready interrupt requested while idle and enabled.
// - Write starts only within master-enable window.
// - Master enable clears itself after four cycles.
// - No write during flash self-programming.
// - Hardware clears write strobe when write ends.
// - Write start stalls CPU two cycles.
// - Read strobe reads current address immediately.
// - Read stalls CPU four cycles.
// - Busy write blocks reads and address changes.
// - Write lasts 8448 ticks of 1 MHz.
// - Address is nine bits, upper bits zero.
// - Data register feeds writes, receives reads.
module eac_ctrl
    import eac_pkg::*;
#(
    parameter int unsigned WRITE_TICKS = WRITE_OSC_CYCLES,
    parameter int unsigned TICK_DIV = OSC_DIV
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // CPU I/O access.
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [1:0] io_sel,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // CPU status.
    input wire logic global_irq_flag,
    input wire logic flash_selfprog_enable,
    output logic ready_irq,
    output logic cpu_stall
);
    import eac_pkg::*;

    logic ready_irq_enable_q, ready_irq_enable_d;
    logic master_write_enable_q, master_write_enable_d;
    logic write_strobe_q, write_strobe_d;
    logic read_strobe_q, read_strobe_d;
    logic [2:0] mwe_cnt_q, mwe_cnt_d;
    logic [8:0] nv_address_q, nv_address_d;
    logic [7:0] nv_data_q, nv_data_d;
    logic [7:0] div_q, div_d;
    logic [13:0] ticks_q, ticks_d;
    logic [2:0] stall_cnt_q, stall_cnt_d;
    logic [7:0] rdata_q, rdata_d;
    logic irq_q, irq_d;
    logic stall_q, stall_d;
    logic wr_ctrl;
    logic start_write;
    logic start_read;
    logic osc_tick;
    logic [7:0] control_view;
    logic [7:0] mem_rdata;

    assign wr_ctrl = io_wr && io_sel == SEL_CONTROL;
    // Strobe counts only inside the enable window and outside flash work.
    assign start_write = wr_ctrl && io_wdata[BIT_WRITE_STROBE]
        && master_write_enable_q && !write_strobe_q
        && !flash_selfprog_enable;
    // No read while a write is still running.
    assign start_read = wr_ctrl && io_wdata[BIT_READ_STROBE]
        && !write_strobe_q;
    assign osc_tick = write_strobe_q && div_q == 8'(TICK_DIV - 1);
    assign control_view = {4'h0, ready_irq_enable_q, master_write_enable_q,
        write_strobe_q, read_strobe_q};

    always_comb
    begin
        ready_irq_enable_d = ready_irq_enable_q;
        master_write_enable_d = master_write_enable_q;
        mwe_cnt_d = mwe_cnt_q;
        write_strobe_d = write_strobe_q;
        read_strobe_d = 1'b0;
        nv_address_d = nv_address_q;
        nv_data_d = nv_data_q;
        div_d = div_q;
        ticks_d = ticks_q;
        stall_cnt_d = stall_cnt_q;
        rdata_d = rdata_q;
        if (mwe_cnt_q != 3'h0)
        begin
            mwe_cnt_d = mwe_cnt_q - 3'h1;
            if (mwe_cnt_q == 3'h1)
            begin
                master_write_enable_d = 1'b0;
            end
        end
        if (wr_ctrl)
        begin
            ready_irq_enable_d = io_wdata[BIT_READY_IRQ_ENABLE];
            if (io_wdata[BIT_MASTER_WRITE_ENABLE])
            begin
                master_write_enable_d = 1'b1;
                mwe_cnt_d = 3'(MWE_HOLD_CYCLES);
            end
        end
        if (start_write)
        begin
            write_strobe_d = 1'b1;
            div_d = 8'h00;
            ticks_d = 14'h0000;
            stall_cnt_d = 3'(WRITE_STALL_CYCLES);
        end
        else if (write_strobe_q)
        begin
            div_d = osc_tick ? 8'h00 : div_q + 8'h01;
            if (osc_tick)
            begin
                ticks_d = ticks_q + 14'h0001;
                if (ticks_q == 14'(WRITE_TICKS - 1))
                begin
                    write_strobe_d = 1'b0;
                end
            end
        end
        if (start_read)
        begin
            read_strobe_d = 1'b1;
            stall_cnt_d = 3'(READ_STALL_CYCLES);
        end
        else if (stall_cnt_q != 3'h0 && !start_write)
        begin
            stall_cnt_d = stall_cnt_q - 3'h1;
        end
        if (read_strobe_q)
        begin
            nv_data_d = mem_rdata;
        end
        if (io_wr && !write_strobe_q && io_sel == SEL_ADDR_LO)
        begin
            nv_address_d[7:0] = io_wdata;
        end
        if (io_wr && !write_strobe_q && io_sel == SEL_ADDR_HI)
        begin
            nv_address_d[8] = io_wdata[0];
        end
        if (io_wr && io_sel == SEL_DATA)
        begin
            nv_data_d = io_wdata;
        end
        if (io_rd)
        begin
            case (io_sel)
                SEL_CONTROL: rdata_d = control_view;
                SEL_ADDR_LO: rdata_d = nv_address_q[7:0];
                SEL_ADDR_HI: rdata_d = {7'h00, nv_address_q[8]};
                SEL_DATA: rdata_d = nv_data_q;
                default: rdata_d = 8'h00;
            endcase
        end
        // Level request while idle and both enables are set.
        irq_d = ready_irq_enable_q && global_irq_flag
            && !write_strobe_q;
        stall_d = stall_cnt_d != 3'h0;
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            ready_irq_enable_q <= CONTROL_RESET[BIT_READY_IRQ_ENABLE];
            master_write_enable_q <= CONTROL_RESET[BIT_MASTER_WRITE_ENABLE];
            write_strobe_q <= CONTROL_RESET[BIT_WRITE_STROBE];
            read_strobe_q <= CONTROL_RESET[BIT_READ_STROBE];
            mwe_cnt_q <= 3'h0;
            nv_address_q <= ADDR_RESET;
            nv_data_q <= DATA_RESET;
            div_q <= 8'h00;
            ticks_q <= 14'h0000;
            stall_cnt_q <= 3'h0;
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
            stall_q <= 1'b0;
        end
        else
        begin
            ready_irq_enable_q <= ready_irq_enable_d;
            master_write_enable_q <= master_write_enable_d;
            write_strobe_q <= write_strobe_d;
            read_strobe_q <= read_strobe_d;
            mwe_cnt_q <= mwe_cnt_d;
            nv_address_q <= nv_address_d;
            nv_data_q <= nv_data_d;
            div_q <= div_d;
            ticks_q <= ticks_d;
            stall_cnt_q <= stall_cnt_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
            stall_q <= stall_d;
        end
    end

    // Array is written at the start of the write, from the data register.
    eac_mem #(
        .AW(ADDR_W),
        .DEPTH(DEPTH)
    ) u_mem (
        .ref_clk(ref_clk),
        .wr_en(start_write),
        .rd_en(start_read),
        .addr(nv_address_q),
        .wdata(nv_data_q),
        .rdata_q(mem_rdata)
    );

    assign io_rdata = rdata_q;
    assign ready_irq = irq_q;
    assign cpu_stall = stall_q;
endmodule : eac_ctrl

// file: verification/eac_ctrl_assertions.sv
// Purpose: Port-level checks for eac_ctrl.
// Assumes: One clock domain and an active-high asynchronous reset.
// Notes: The age counter tracks cycles since the master enable was written.
module eac_chk
    import eac_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Watched ports.
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [1:0] io_sel,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic global_irq_flag,
    input wire logic flash_selfprog_enable,
    input wire logic ready_irq,
    input wire logic cpu_stall
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic ctl_wr;
    logic [3:0] age_d;
    logic [3:0] age_q;
    assign ctl_wr = io_wr && io_sel == SEL_CONTROL;
    always_comb
    begin
        age_d = age_q;
        if (ctl_wr && io_wdata[2])
            age_d = 4'h1;
        else if (age_q != 4'hf)
            age_d = age_q + 4'h1;
    end
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            age_q <= 4'hf;
        else
            age_q <= age_d;
    end
    a_ctrl_high_zero: assert property (
        $past(io_rd) && $past(io_sel) == SEL_CONTROL |-> io_rdata[7:4] == 4'h0)
        else $error("control upper bits not zero");
    a_addr_high_zero: assert property (
        $past(io_rd) && $past(io_sel) == SEL_ADDR_HI |-> io_rdata[7:1] == 7'h00)
        else $error("address high reserved bits not zero");
    a_rdata_holds: assert property (
        !$past(io_rd) |-> $stable(io_rdata))
        else $error("read data moved without a read");
    a_irq_needs_global: assert property (
        ready_irq |-> $past(global_irq_flag))
        else $error("ready request without global flag");
    a_irq_disable: assert property (
        ctl_wr && !io_wdata[3] |-> ##2 !ready_irq)
        else $error("ready request stayed after disable");
    a_stall_length: assert property (
        $rose(cpu_stall) |-> (cpu_stall[*2] ##1 !cpu_stall)
        or (cpu_stall[*4] ##1 !cpu_stall))
        else $error("stall length wrong");
    a_mwe_timeout: assert property (
        ctl_wr && io_wdata[2:0] == 3'h2 && age_q > 4'h4 |=> !$rose(cpu_stall))
        else $error("write started after enable timeout");
    a_flash_blocks: assert property (
        ctl_wr && io_wdata[1:0] == 2'h2 && flash_selfprog_enable
        |=> !$rose(cpu_stall))
        else $error("write started during flash programming");
    c_read: cover property ($rose(cpu_stall) ##1 cpu_stall[*3]);
    c_irq: cover property ($rose(ready_irq));
    c_write: cover property (ctl_wr && io_wdata[1] && age_q < 4'h5);
endmodule : eac_chk
bind eac_ctrl eac_chk eac_chk_inst (.ref_clk(ref_clk), .reset(reset),
    .io_wr(io_wr), .io_rd(io_rd), .io_sel(io_sel), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .global_irq_flag(global_irq_flag),
    .flash_selfprog_enable(flash_selfprog_enable), .ready_irq(ready_irq),
    .cpu_stall(cpu_stall));

// file: verification/testbench.sv
// Purpose: Self-checking bench for eac_ctrl.
// Assumes: Short write time through WRITE_TICKS 8 and TICK_DIV 2.
// Notes: Stall lengths are measured by a monitor of cpu_stall.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import eac_pkg::*;
    logic ref_clk = 0, reset = 1, io_wr = 0, io_rd = 0;
    logic global_irq_flag = 0, flash_selfprog_enable = 0;
    logic [1:0] io_sel = 0;
    logic [7:0] io_wdata = 0, io_rdata, v;
    logic ready_irq, cpu_stall;
    logic [15:0] lfsr = 16'h0063;
    logic [8:0] a;
    logic [7:0] d;
    int errors = 0, compares = 0, cycles = 0, run = 0, last = 0;
    int runs_done = 0;
    eac_ctrl #(.WRITE_TICKS(8), .TICK_DIV(2)) eac_ctrl_inst (
        .ref_clk(ref_clk), .reset(reset), .io_wr(io_wr), .io_rd(io_rd),
        .io_sel(io_sel), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .global_irq_flag(global_irq_flag), .ready_irq(ready_irq),
        .flash_selfprog_enable(flash_selfprog_enable), .cpu_stall(cpu_stall));
    always #2 ref_clk = ~ref_clk;
    task report_and_stop;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cpu_stall === 1'b1)
            run++;
        else if (run != 0)
        begin
            last = run;
            run = 0;
            runs_done++;
        end
        if (cycles > 20000)
        begin
            errors++;
            report_and_stop;
        end
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    function automatic logic [7:0] ctrl_exp(input logic ie, input logic mw,
        input logic ws);
        return {4'h0, ie, mw, ws, 1'b0};
    endfunction : ctrl_exp
    task wr(input logic [1:0] s, input logic [7:0] x);
        @(posedge ref_clk);
        io_wr <= 1;
        io_sel <= s;
        io_wdata <= x;
        @(posedge ref_clk);
        io_wr <= 0;
    endtask : wr
    task rd(input logic [1:0] s, output logic [7:0] x);
        @(posedge ref_clk);
        io_rd <= 1;
        io_sel <= s;
        @(posedge ref_clk);
        io_rd <= 0;
        @(posedge ref_clk);
        #1 x = io_rdata;
    endtask : rd
    task set_addr(input logic [8:0] x);
        wr(SEL_ADDR_LO, x[7:0]);
        wr(SEL_ADDR_HI, {7'h00, x[8]});
    endtask : set_addr
    task write_byte(input logic [8:0] x, input logic [7:0] y);
        global_irq_flag <= 1'b0;
        set_addr(x);
        wr(SEL_DATA, y);
        wr(SEL_CONTROL, 8'h0c);
        wr(SEL_CONTROL, 8'h0e);
        repeat (4) @(posedge ref_clk);
        global_irq_flag <= 1'b1;
    endtask : write_byte
    task wait_idle;
        v = 8'h02;
        for (int i = 0; i < 4 && v[1] !== 1'b0; i++)
            rd(SEL_CONTROL, v);
        chk(v & 8'h02, 8'h00);
    endtask : wait_idle
    task read_check(input logic [8:0] x, input logic [7:0] y);
        int n;
        n = runs_done;
        set_addr(x);
        wr(SEL_CONTROL, 8'h09);
        rd(SEL_DATA, v);
        chk(v, y);
        rd(SEL_CONTROL, v);
        chk(v & 8'h01, 8'h00);
        chk(8'(last), 8'h04);
        chk(8'(runs_done - n), 8'h01);
    endtask : read_check
    initial
    begin
        repeat (16) @(posedge ref_clk);
        reset <= 0;
        rd(SEL_CONTROL, v);
        chk(v, 8'h00);
        global_irq_flag <= 1;
        wr(SEL_CONTROL, 8'h08);
        repeat (3) @(posedge ref_clk);
        chk({7'h00, ready_irq}, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            lfsr = lfsr_next(lfsr);
            a = (i == 0) ? 9'h1ff : lfsr[8:0];
            d = lfsr[15:8];
            write_byte(a, d);
            chk(8'(last), 8'h02);
            wr(SEL_ADDR_LO, ~a[7:0]);
            wr(SEL_CONTROL, 8'h09);
            rd(SEL_ADDR_LO, v);
            chk(v, a[7:0]);
            chk({7'h00, ready_irq}, 8'h00);
            rd(SEL_CONTROL, v);
            chk(v, ctrl_exp(1'b1, 1'b0, 1'b1));
            chk(8'(last), 8'h02);
            wait_idle;
            read_check(a, d);
            chk({7'h00, ready_irq}, 8'h01);
            rd(SEL_ADDR_HI, v);
            chk(v, {7'h00, a[8]});
        end
        flash_selfprog_enable <= 1;
        write_byte(a, ~d);
        rd(SEL_CONTROL, v);
        chk(v, 8'h08);
        flash_selfprog_enable <= 0;
        wr(SEL_CONTROL, 8'h0c);
        rd(SEL_CONTROL, v);
        chk(v, 8'h0c);
        rd(SEL_CONTROL, v);
        chk(v, 8'h08);
        wr(SEL_CONTROL, 8'h0a);
        rd(SEL_CONTROL, v);
        chk(v, 8'h08);
        read_check(a, d);
        global_irq_flag <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk({7'h00, ready_irq}, 8'h00);
        global_irq_flag <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk({7'h00, ready_irq}, 8'h01);
        wr(SEL_CONTROL, 8'h00);
        repeat (3) @(posedge ref_clk);
        chk({7'h00, ready_irq}, 8'h00);
        report_and_stop;
    end
endmodule : testbench
